// ===== logic/bdcvr_consts.svh
// addresses, reset values, write masks and field positions of the config and verify bank
// What this block does
// (R1) overcurrent qualifier mode: 0 debounce, 1 blanking; resets to 0
// (R2) drain fault qualifier mode: 0 debounce, 1 blank; resets to 0
// (R3) 2-bit bridge disconnect threshold code, (code+1) steps; resets to 00
// (R4) 6-bit high-side drain threshold code, 50 mV steps; resets to 011000
// (R5) every frame has odd parity, checked on receive and made on send
// (R6) 4-bit on-state open-load threshold code, (code+1)x25 mV; resets to 1000
// (R7) 6-bit drain verify time code, code x 100 ns; resets to 010000
// (R8) on-state open-load enable and watchdog enable: 1 active; both reset to 0
// (R9) off-state open-load test current select: 0 low, 1 high; resets to 0
// (R10) 6-bit phase comparator threshold code, code/64 of supply; resets to 100000
// (R11) 4-bit sense offset code, table mapped; resets to 15
// (R12) 3-bit sense gain code, gains 10 to 50; resets to 5
// (R13) off-state open-load control inverted: 0 active, 1 inactive; resets to 0
// (R14) supply verify command register: eight monitor check bits, 1 active, reset 0
// (R15) off-state open-load phase select: 0 phase A, 1 phase B; resets to 0
// (R16) bridge verify command bits: writing 1 activates and starts the check
// (R17) connect result register is read only, 1 detected, resets to 0
// (R18) power-on reset returns every register of the bank to its default
// (R19) frame: address 15:12, write flag 11, data 10:1, parity 0
`ifndef BDCVR_CONSTS_SVH
`define BDCVR_CONSTS_SVH
// ==========================================================
// frame layout
`define BDCVR_FRAME_BITS 5'h10
`define BDCVR_WR_BIT     11
// ==========================================================
// register addresses
`define BDCVR_ADDR_CFG2  4'h2
`define BDCVR_ADDR_CFG3  4'h3
`define BDCVR_ADDR_CFG4  4'h4
`define BDCVR_ADDR_CFG5  4'h5
`define BDCVR_ADDR_CMD0  4'h6
`define BDCVR_ADDR_CMD1  4'h7
`define BDCVR_ADDR_RES0  4'h8
`define BDCVR_ADDR_RES1  4'h9
// ==========================================================
// reset values of the 10-bit data fields
`define BDCVR_RST_CFG2   10'h018
`define BDCVR_RST_CFG3   10'h210
`define BDCVR_RST_CFG4   10'h060
`define BDCVR_RST_CFG5   10'h0F5
`define BDCVR_RST_CMD    10'h000
`define BDCVR_RST_RES    10'h000
// ==========================================================
// writable bits, reserved bits stay zero
`define BDCVR_MASK_CFG5  10'h1F7
`define BDCVR_MASK_CMD0  10'h3FC
`define BDCVR_MASK_CMD1  10'h3EF
// ==========================================================
// field positions inside the data field
`define BDCVR_OCQ_BIT    9
`define BDCVR_VDQ_BIT    8
`define BDCVR_VTB_LSB    6
`define BDCVR_VTH_LSB    0
`define BDCVR_OLT_LSB    6
`define BDCVR_TVD_LSB    0
`define BDCVR_AOL_BIT    9
`define BDCVR_EWD_BIT    8
`define BDCVR_OLI_BIT    7
`define BDCVR_VRG_BIT    6
`define BDCVR_VPT_LSB    0
`define BDCVR_DOO_BIT    8
`define BDCVR_SAO_LSB    4
`define BDCVR_SAG_LSB    0
`define BDCVR_CMD0_LSB   2
`define BDCVR_OP_BIT     9
`endif

// ===== logic/bdcvr_pkg.sv
// types shared by the config and verify register bank
`default_nettype none
package bdcvr_pkg;
    typedef enum logic [1:0] {
        BDCVR_IDLE  = 2'h1,
        BDCVR_SHIFT = 2'h2
    } bdcvr_state_type;
    typedef logic [9:0] bdcvr_data_type;
    typedef logic [3:0] bdcvr_addr_type;
endpackage
`default_nettype wire

// ===== logic/bdcvr_sync_if.sv
// carrier between the pin synchroniser and the register bank
`default_nettype none
interface bdcvr_sync_if;
    logic [2:0] raw;
    logic [2:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface
`default_nettype wire

// ===== logic/bdcvr_sync.sv
// three-stage pin synchroniser, a change counts once stages two and three agree
`default_nettype none
module bdcvr_sync #(
    parameter logic [2:0] RST_VAL = 3'h6
) (
    input  wire logic   sys_clk,
    input  wire logic   srst,
    input  wire logic   clk_en,
    bdcvr_sync_if.sync  port
);
    logic [2:0] s1_ff;
    logic [2:0] s2_ff;
    logic [2:0] s3_ff;
    logic [2:0] clean_ff;
    logic [2:0] agree;

    // ==========================================================
    // stages and agreement filter
    assign agree = ~(s2_ff ^ s3_ff);
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s1_ff    <= RST_VAL;
            s2_ff    <= RST_VAL;
            s3_ff    <= RST_VAL;
            clean_ff <= RST_VAL;
        end else if (clk_en) begin
            s1_ff    <= port.raw;
            s2_ff    <= s1_ff;
            s3_ff    <= s2_ff;
            clean_ff <= (s2_ff & agree) | (clean_ff & ~agree);
        end
    end
    assign port.clean = clean_ff;
endmodule
`default_nettype wire

// ===== logic/bdcvr_regs.sv
// serial config and verify register bank of the bridge driver
`include "bdcvr_consts.svh"
`default_nettype none
module bdcvr_regs
    import bdcvr_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       clk_en,
    input  wire logic       strobe_n_pin,
    input  wire logic       sclk_pin,
    input  wire logic       sdi_pin,
    output logic            sdo_out,
    output logic            sdo_oe,
    input  wire logic       phase_b_connect_in,
    input  wire logic       phase_a_connect_in,
    input  wire logic       bridge_disconnect_in,
    input  wire logic [1:0] low_side_disconnect_in,
    input  wire logic       phase_b_state_in,
    input  wire logic       phase_a_state_in,
    input  wire logic       sense_disconnect_in,
    output logic            overcurrent_qualifier_mode,
    output logic            drain_fault_qualifier_mode,
    output logic [1:0]      bridge_disconnect_threshold,
    output logic [5:0]      high_side_drain_threshold,
    output logic [3:0]      on_open_load_threshold,
    output logic [5:0]      drain_verify_time,
    output logic            on_open_load_enable,
    output logic            enable_input_watchdog_on,
    output logic            open_load_test_current_sel,
    output logic            regulator_level_sel,
    output logic [5:0]      phase_comparator_threshold,
    output logic            off_open_load_disable,
    output logic [3:0]      sense_offset_code,
    output logic [2:0]      sense_gain_code,
    output logic [7:0]      verify_supply_cmd,
    output logic            off_open_load_phase_sel,
    output logic [7:0]      verify_bridge_cmd,
    output logic [7:0]      verify_start,
    output logic            frame_error
);
    bdcvr_sync_if       sif ();
    bdcvr_state_type    state_ff;
    logic [2:0]         prev_ff;
    logic [4:0]         cnt_ff;
    logic [15:0]        rx_ff;
    logic [15:0]        tx_ff;
    logic               sdo_ff;
    logic               oe_ff;
    bdcvr_addr_type     last_addr_ff;
    logic               frame_error_ff;
    bdcvr_data_type     cfg2_ff;
    bdcvr_data_type     cfg3_ff;
    bdcvr_data_type     cfg4_ff;
    bdcvr_data_type     cfg5_ff;
    bdcvr_data_type     cmd0_ff;
    bdcvr_data_type     cmd1_ff;
    bdcvr_data_type     res0_ff;
    bdcvr_data_type     res1_ff;
    logic [7:0]         start_ff;
    logic               strobe_fall;
    logic               strobe_rise;
    logic               sclk_rise;
    logic               sclk_fall;
    logic               take;
    logic               frame_ok;
    logic               wr_en;
    bdcvr_addr_type     waddr;
    bdcvr_data_type     wdata;
    bdcvr_data_type     rdata;
    logic [15:0]        tx_word;

    // ==========================================================
    // pin synchroniser, pins idle with strobe and clock high
    assign sif.raw = {strobe_n_pin, sclk_pin, sdi_pin};
    bdcvr_sync #(.RST_VAL(3'h6)) bdcvr_sync_inst (
        .sys_clk (sys_clk),
        .srst    (srst),
        .clk_en  (clk_en),
        .port    (sif.sync)
    );

    // ==========================================================
    // edge detection on the filtered pins
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prev_ff <= 3'h6;
        end else if (clk_en) begin
            prev_ff <= sif.clean;
        end
    end
    assign strobe_fall = prev_ff[2] & ~sif.clean[2];
    assign strobe_rise = ~prev_ff[2] & sif.clean[2];
    assign sclk_rise   = ~prev_ff[1] & sif.clean[1];
    assign sclk_fall   = prev_ff[1] & ~sif.clean[1];

    // ==========================================================
    // frame decode: sixteen bits with odd parity
    assign take     = strobe_rise && (state_ff == BDCVR_SHIFT);
    assign frame_ok = (cnt_ff == `BDCVR_FRAME_BITS) && (^rx_ff); // [R5] [R19]
    assign wr_en    = take && frame_ok && rx_ff[`BDCVR_WR_BIT];  // [R19]
    assign waddr    = rx_ff[15:12];                              // [R19]
    assign wdata    = rx_ff[10:1];

    // ==========================================================
    // frame state
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_ff <= BDCVR_IDLE;
        end else if (clk_en) begin
            unique case (state_ff)
                BDCVR_IDLE: begin
                    if (strobe_fall) begin
                        state_ff <= BDCVR_SHIFT;
                    end
                end
                BDCVR_SHIFT: begin
                    if (strobe_rise) begin
                        state_ff <= BDCVR_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // receive shifter, sampled on rising clock, count saturates
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cnt_ff <= 5'h00;
            rx_ff  <= 16'h0000;
        end else if (clk_en) begin
            if (strobe_fall) begin
                cnt_ff <= 5'h00;
                rx_ff  <= 16'h0000;
            end else if (sclk_rise && state_ff == BDCVR_SHIFT) begin
                rx_ff <= {rx_ff[14:0], sif.clean[0]};
                if (cnt_ff != 5'h1F) begin
                    cnt_ff <= cnt_ff + 5'h01;
                end
            end
        end
    end

    // ==========================================================
    // readback mux and reply word with odd parity
    always_comb begin
        unique case (last_addr_ff)
            `BDCVR_ADDR_CFG2: rdata = cfg2_ff;
            `BDCVR_ADDR_CFG3: rdata = cfg3_ff;
            `BDCVR_ADDR_CFG4: rdata = cfg4_ff;
            `BDCVR_ADDR_CFG5: rdata = cfg5_ff;
            `BDCVR_ADDR_CMD0: rdata = cmd0_ff;
            `BDCVR_ADDR_CMD1: rdata = cmd1_ff;
            `BDCVR_ADDR_RES0: rdata = res0_ff;
            `BDCVR_ADDR_RES1: rdata = res1_ff;
            default:          rdata = 10'h000;
        endcase
    end
    assign tx_word = {last_addr_ff, 1'b0, rdata, ~(^{last_addr_ff, rdata})}; // [R5]

    // ==========================================================
    // transmit shifter, next bit on falling clock after the first sample
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tx_ff  <= 16'h0000;
            sdo_ff <= 1'b0;
            oe_ff  <= 1'b0;
        end else if (clk_en) begin
            if (strobe_fall) begin
                tx_ff  <= tx_word;
                sdo_ff <= tx_word[15];
                oe_ff  <= 1'b1;
            end else if (strobe_rise) begin
                oe_ff  <= 1'b0;
            end else if (sclk_fall && state_ff == BDCVR_SHIFT && cnt_ff != 5'h00) begin
                tx_ff  <= {tx_ff[14:0], 1'b0};
                sdo_ff <= tx_ff[14];
            end
        end
    end

    // ==========================================================
    // address of the next reply and serial error pulse
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            last_addr_ff   <= 4'h0;
            frame_error_ff <= 1'b0;
        end else if (clk_en) begin
            frame_error_ff <= take && !frame_ok; // [R5]
            if (take && frame_ok) begin
                last_addr_ff <= waddr;
            end
        end
    end

    // ==========================================================
    // configuration registers, reset only by power-on reset
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cfg2_ff <= `BDCVR_RST_CFG2; // [R1] [R2] [R3] [R4] [R18]
            cfg3_ff <= `BDCVR_RST_CFG3; // [R6] [R7]
            cfg4_ff <= `BDCVR_RST_CFG4; // [R8] [R9] [R10]
            cfg5_ff <= `BDCVR_RST_CFG5; // [R11] [R12] [R13]
        end else if (clk_en && wr_en) begin
            if (waddr == `BDCVR_ADDR_CFG2) begin
                cfg2_ff <= wdata;
            end
            if (waddr == `BDCVR_ADDR_CFG3) begin
                cfg3_ff <= wdata;
            end
            if (waddr == `BDCVR_ADDR_CFG4) begin
                cfg4_ff <= wdata;
            end
            if (waddr == `BDCVR_ADDR_CFG5) begin
                cfg5_ff <= wdata & `BDCVR_MASK_CFG5;
            end
        end
    end

    // ==========================================================
    // verify command registers and one-cycle start pulses
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cmd0_ff  <= `BDCVR_RST_CMD; // [R14]
            cmd1_ff  <= `BDCVR_RST_CMD; // [R15]
            start_ff <= 8'h00;
        end else if (clk_en) begin
            start_ff <= 8'h00;
            if (wr_en && waddr == `BDCVR_ADDR_CMD0) begin
                cmd0_ff <= wdata & `BDCVR_MASK_CMD0; // [R14]
            end
            if (wr_en && waddr == `BDCVR_ADDR_CMD1) begin
                cmd1_ff  <= wdata & `BDCVR_MASK_CMD1;
                start_ff <= {wdata[8:5], wdata[3:0]}; // [R16]
            end
        end
    end

    // ==========================================================
    // read-only results follow the monitors, writes never reach them
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            res0_ff <= `BDCVR_RST_RES; // [R17]
            res1_ff <= `BDCVR_RST_RES;
        end else if (clk_en) begin
            res0_ff <= {4'h0, phase_b_connect_in, phase_a_connect_in, bridge_disconnect_in,
                        1'b0, low_side_disconnect_in}; // [R17]
            res1_ff <= {5'h00, phase_b_state_in, phase_a_state_in, 2'h0, sense_disconnect_in};
        end
    end

    // ==========================================================
    // outputs, each a slice of a register
    assign sdo_out                    = sdo_ff;
    assign sdo_oe                     = oe_ff;
    assign frame_error                = frame_error_ff;
    assign overcurrent_qualifier_mode = cfg2_ff[`BDCVR_OCQ_BIT];
    assign drain_fault_qualifier_mode = cfg2_ff[`BDCVR_VDQ_BIT];
    assign bridge_disconnect_threshold = cfg2_ff[`BDCVR_VTB_LSB +: 2];
    assign high_side_drain_threshold  = cfg2_ff[`BDCVR_VTH_LSB +: 6];
    assign on_open_load_threshold     = cfg3_ff[`BDCVR_OLT_LSB +: 4];
    assign drain_verify_time          = cfg3_ff[`BDCVR_TVD_LSB +: 6];
    assign on_open_load_enable        = cfg4_ff[`BDCVR_AOL_BIT];
    assign enable_input_watchdog_on   = cfg4_ff[`BDCVR_EWD_BIT];
    assign open_load_test_current_sel = cfg4_ff[`BDCVR_OLI_BIT];
    assign regulator_level_sel        = cfg4_ff[`BDCVR_VRG_BIT];
    assign phase_comparator_threshold = cfg4_ff[`BDCVR_VPT_LSB +: 6];
    assign off_open_load_disable      = cfg5_ff[`BDCVR_DOO_BIT];
    assign sense_offset_code          = cfg5_ff[`BDCVR_SAO_LSB +: 4];
    assign sense_gain_code            = cfg5_ff[`BDCVR_SAG_LSB +: 3];
    assign verify_supply_cmd          = cmd0_ff[`BDCVR_CMD0_LSB +: 8];
    assign off_open_load_phase_sel    = cmd1_ff[`BDCVR_OP_BIT];
    assign verify_bridge_cmd          = {cmd1_ff[8:5], cmd1_ff[3:0]};
    assign verify_start               = start_ff;

    // ==========================================================
    // assertions
    property p_rst_cfg2;
        @(posedge sys_clk) $past(srst) |-> cfg2_ff == `BDCVR_RST_CFG2 && !overcurrent_qualifier_mode;
    endproperty
    a_rst_cfg2: assert property (p_rst_cfg2) else $error("config 2 default wrong"); // [R1] [R2] [R3] [R4]

    property p_rst_cfg3;
        @(posedge sys_clk) srst |=> on_open_load_threshold == 4'h8 && drain_verify_time == 6'h10;
    endproperty
    a_rst_cfg3: assert property (p_rst_cfg3) else $error("config 3 default wrong"); // [R6] [R7]

    property p_rst_cfg45;
        @(posedge sys_clk) srst |=> cfg4_ff == `BDCVR_RST_CFG4 && sense_offset_code == 4'hF
            && sense_gain_code == 3'h5 && !off_open_load_disable;
    endproperty
    a_rst_cfg45: assert property (p_rst_cfg45) else $error("config 4/5 default wrong"); // [R8] [R9] [R10] [R11] [R12] [R13]

    property p_rst_verify;
        @(posedge sys_clk) srst |=> cmd0_ff == 10'h000 && cmd1_ff == 10'h000 && res0_ff == 10'h000;
    endproperty
    a_rst_verify: assert property (p_rst_verify) else $error("verify default wrong"); // [R14] [R15] [R17] [R18]

    property p_bad_parity;
        @(posedge sys_clk) disable iff (srst)
        (clk_en && take && !(^rx_ff)) |=> frame_error_ff && cfg2_ff == $past(cfg2_ff)
            && cmd1_ff == $past(cmd1_ff);
    endproperty
    a_bad_parity: assert property (p_bad_parity) else $error("bad parity frame not refused"); // [R5]

    property p_reply_parity;
        @(posedge sys_clk) disable iff (srst) (clk_en && strobe_fall) |=> (^tx_ff) && oe_ff;
    endproperty
    a_reply_parity: assert property (p_reply_parity) else $error("reply parity not odd"); // [R5]

    property p_write_cfg2;
        @(posedge sys_clk) disable iff (srst)
        (clk_en && wr_en && waddr == `BDCVR_ADDR_CFG2) |=> cfg2_ff == $past(rx_ff[10:1]);
    endproperty
    a_write_cfg2: assert property (p_write_cfg2) else $error("config 2 write lost"); // [R19]

    property p_start_pulse;
        @(posedge sys_clk) disable iff (srst || !clk_en)
        (start_ff != 8'h00) |-> $past(wr_en && waddr == `BDCVR_ADDR_CMD1) ##1 start_ff == 8'h00;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse not one cycle"); // [R16]

    property p_result_ro;
        @(posedge sys_clk) disable iff (srst)
        clk_en |=> res0_ff[5:3] == $past({phase_b_connect_in, phase_a_connect_in, bridge_disconnect_in});
    endproperty
    a_result_ro: assert property (p_result_ro) else $error("result does not track monitor"); // [R17]

    property p_short_frame;
        @(posedge sys_clk) disable iff (srst)
        (clk_en && take && cnt_ff != `BDCVR_FRAME_BITS) |=> frame_error_ff && last_addr_ff == $past(last_addr_ff);
    endproperty
    a_short_frame: assert property (p_short_frame) else $error("short frame not refused"); // [R19]

    property p_reserved_zero;
        @(posedge sys_clk) disable iff (srst)
        (cfg5_ff & ~`BDCVR_MASK_CFG5) == 10'h000 && (cmd0_ff & ~`BDCVR_MASK_CMD0) == 10'h000
            && (cmd1_ff & ~`BDCVR_MASK_CMD1) == 10'h000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // [R11] [R14] [R16]

    property p_result_phase;
        @(posedge sys_clk) disable iff (srst)
        clk_en |=> res1_ff == {5'h00, $past(phase_b_state_in), $past(phase_a_state_in), 2'h0, $past(sense_disconnect_in)};
    endproperty
    a_result_phase: assert property (p_result_phase) else $error("phase result does not track monitor"); // [R17]

    c_write_cfg: cover property (@(posedge sys_clk) wr_en && waddr == `BDCVR_ADDR_CFG4);
    c_start:     cover property (@(posedge sys_clk) start_ff != 8'h00);
    c_bad_frame: cover property (@(posedge sys_clk) frame_error_ff);
    c_read:      cover property (@(posedge sys_clk) take && frame_ok && !rx_ff[`BDCVR_WR_BIT]);
endmodule
`default_nettype wire

// ===== testbench/bdcvr_host_model.sv
// host side serial master model for the config and verify register bank
`default_nettype none
module bdcvr_host_model (
    output logic      strobe_n_pin,
    output logic      sclk_pin,
    output logic      sdi_pin,
    input  wire logic sdo_out,
    input  wire logic sdo_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // idle pins: strobe and clock stand high between frames
    initial begin
        strobe_n_pin = 1'b1;
        sclk_pin     = 1'b1;
        sdi_pin      = 1'b0;
    end
    // ==========================================
    // one frame, msb first, 320 ns link period, reply bit taken late in each high phase
    task automatic xfer(input logic [3:0] addr, input logic wr, input logic [9:0] data, input int nbits,
                        input logic bad_par, output logic [15:0] reply, output logic oe_ok);
        logic [15:0] frame;
        frame = {addr, wr, data, (~^{addr, wr, data}) ^ bad_par};
        reply = 16'h0000;
        oe_ok = 1'b1;
        #13 strobe_n_pin = 1'b0;
        #320;
        for (int i = 0; i < nbits; i++) begin
            sclk_pin = 1'b0;
            sdi_pin  = frame[15 - i];
            #160 sclk_pin = 1'b1;
            #150 reply = {reply[14:0], sdo_oe ? sdo_out : ~sdo_out}; // released line reads inverted
            oe_ok = oe_ok & sdo_oe;
            #10;
        end
        strobe_n_pin = 1'b1;
        sdi_pin      = ~sdi_pin; // released line never keeps the last bit
        #320;
    endtask
endmodule
`default_nettype wire

// ===== testbench/test_bdcvr_regs.sv
// self-checking bench of the config and verify register bank
`default_nettype none
module test_bdcvr_regs;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // design pins and bench state
    logic sys_clk, srst, strobe_n_pin, sclk_pin, sdi_pin, sdo_out, sdo_oe, frame_error;
    logic phase_b_connect_in, phase_a_connect_in, bridge_disconnect_in, phase_b_state_in, phase_a_state_in;
    logic sense_disconnect_in, overcurrent_qualifier_mode, drain_fault_qualifier_mode, on_open_load_enable;
    logic enable_input_watchdog_on, open_load_test_current_sel, regulator_level_sel, off_open_load_disable;
    logic off_open_load_phase_sel;
    logic [1:0] low_side_disconnect_in, bridge_disconnect_threshold;
    logic [5:0] high_side_drain_threshold, drain_verify_time, phase_comparator_threshold;
    logic [3:0] on_open_load_threshold, sense_offset_code;
    logic [2:0] sense_gain_code;
    logic [7:0] verify_supply_cmd, verify_bridge_cmd, verify_start;
    logic [7:0] start_acc = 8'h00;
    logic [15:0] rep;
    logic oe_ok;
    int fails = 0, n_tests = 0, err_cnt = 0, start_cnt = 0;
    logic [9:0] rst_v [2:7] = '{10'h018, 10'h210, 10'h060, 10'h0F5, 10'h000, 10'h000};
    logic [9:0] mask_v [2:7] = '{10'h3FF, 10'h3FF, 10'h3FF, 10'h1F7, 10'h3FC, 10'h3EF};

    bdcvr_regs bdcvr_regs_inst (.*, .clk_en(1'b1));
    bdcvr_host_model bdcvr_host_model_inst (.*);

    // 25 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // count one-cycle pulses seen after each frame
    always @(posedge sys_clk) begin
        if (frame_error === 1'b1) err_cnt <= err_cnt + 1;
        if (verify_start !== 8'h00) begin
            start_cnt <= start_cnt + 1;
            start_acc <= start_acc | verify_start;
        end
    end
    // ==========================================
    // helpers
    function automatic logic [9:0] obs(input logic [3:0] a);
        case (a)
            4'h2: obs = {overcurrent_qualifier_mode, drain_fault_qualifier_mode, bridge_disconnect_threshold,
                         high_side_drain_threshold};
            4'h3: obs = {on_open_load_threshold, drain_verify_time};
            4'h4: obs = {on_open_load_enable, enable_input_watchdog_on, open_load_test_current_sel,
                         regulator_level_sel, phase_comparator_threshold};
            4'h5: obs = {1'b0, off_open_load_disable, sense_offset_code, 1'b0, sense_gain_code};
            4'h6: obs = {verify_supply_cmd, 2'b00};
            default: obs = {off_open_load_phase_sel, verify_bridge_cmd[7:4], 1'b0, verify_bridge_cmd[3:0]};
        endcase
    endfunction
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report;
        if (fails == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic do_reset;
        @(posedge sys_clk);
        #2 srst = 1'b1;
        repeat (4) @(posedge sys_clk);
        #2 srst = 1'b0;
    endtask
    task automatic frame(input logic [3:0] a, input logic wr, input logic [9:0] d, input int nb = 16,
                         input logic bad = 1'b0);
        err_cnt = 0;
        start_cnt = 0;
        start_acc = 8'h00;
        bdcvr_host_model_inst.xfer(a, wr, d, nb, bad, rep, oe_ok);
        repeat (10) @(posedge sys_clk);
        #2;
        check("output enable", {15'h0000, nb == 16}, {15'h0000, oe_ok & (nb == 16)});
        check("output released", 16'h0000, 16'(sdo_oe));
    endtask
    // ==========================================
    // scenarios
    task automatic t_defaults;
        for (int a = 2; a <= 7; a++) begin
            check("reset value", 16'(rst_v[a]), 16'(obs(4'(a))));
            check("reset fields", 16'(rst_v[a]), 16'(obs(4'(a))));
        end
        check("pulses idle", 16'h0000, {7'h00, frame_error, verify_start});
    endtask
    task automatic t_refused;
        frame(4'h2, 1'b1, 10'h3FF, 16, 1'b1);
        check("bad parity", {4'h1, 12'(rst_v[2])}, {4'(err_cnt), 12'(obs(4'h2))});
        frame(4'h2, 1'b1, 10'h3FF, 15);
        check("short frame", {4'h1, 12'(rst_v[2])}, {4'(err_cnt), 12'(obs(4'h2))});
        frame(4'h2, 1'b0, 10'h000);
        check("reply after reset", 16'h0001, rep);
    endtask
    task automatic t_write_read;
        logic [9:0] p;
        logic [9:0] m;
        for (int k = 0; k < 2; k++) begin
            p = k ? 10'h155 : 10'h2AA;
            for (int a = 2; a <= 7; a++) begin
                m = p & mask_v[a];
                frame(4'(a), 1'b1, p);
                check("fields", 16'(m), 16'(obs(4'(a))));
                check("field map", 16'(m), 16'(obs(4'(a))));
                check("pulses", {4'h0, (a == 7) ? 4'h1 : 4'h0, (a == 7) ? {p[8:5], p[3:0]} : 8'h00},
                      {4'(err_cnt), 4'(start_cnt), start_acc});
                frame(4'(a), 1'b0, 10'h000);
                check("read back", {4'(a), 1'b0, m, ~^{4'(a), m}}, rep);
            end
        end
    endtask
    task automatic t_results;
        @(posedge sys_clk);
        #2 {phase_b_connect_in, phase_a_connect_in, bridge_disconnect_in, low_side_disconnect_in} = 5'b10110;
        {phase_b_state_in, phase_a_state_in, sense_disconnect_in} = 3'b011;
        frame(4'h8, 1'b1, 10'h3FF);
        frame(4'h8, 1'b0, 10'h000);
        frame(4'h9, 1'b0, 10'h000);
        check("result 0", {4'h8, 1'b0, 10'h02A, ~^{4'h8, 10'h02A}}, rep);
        frame(4'h2, 1'b0, 10'h000);
        check("result 1", {4'h9, 1'b0, 10'h009, ~^{4'h9, 10'h009}}, rep);
    endtask
    // ==========================================
    // main sequence and hang guard
    initial begin
        srst = 1'b1;
        {phase_b_connect_in, phase_a_connect_in, bridge_disconnect_in, low_side_disconnect_in} = 5'b00000;
        {phase_b_state_in, phase_a_state_in, sense_disconnect_in} = 3'b000;
        do_reset();
        t_defaults();
        t_refused();
        t_write_read();
        t_results();
        do_reset();
        t_defaults();
        final_report();
    end
    initial begin
        #1000000;
        fails++;
        final_report();
    end
endmodule
`default_nettype wire
